/* File: logic/pdadc_pkg.sv */
// Constants and types for the power detector converter readout
package pdadc_pkg;

   // ****************************************
   // Data widths
   // ****************************************
   localparam int RESULT_W   = 12;
   localparam int FIFO_DEPTH = 32;
   localparam int IN_W       = 20;
   localparam int FRAC_W     = 4;

   // ****************************************
   // Codes
   // ****************************************
   localparam logic [RESULT_W-1:0] CODE_ALL_ONES  = 12'hfff;
   localparam logic [RESULT_W-1:0] CODE_ALL_ZEROS = 12'h000;
   localparam logic [RESULT_W-1:0] RESULT_RST     = 12'h000;
   localparam logic signed [IN_W:0] HALF_STEP     = 21'sh00008;
   localparam logic signed [IN_W:0] TOP_CODE      = 21'sh00fff;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam int ACQ_TIME_NS   = 500;
   localparam int CONVERSION_TRIGGER_TIME_NS  = 2000;
   localparam int ACQ_CYCLES    = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONVERSION_TRIGGER_CYCLES   = (CONVERSION_TRIGGER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W         = 8;

   // ****************************************
   // Converter states
   // ****************************************
   typedef enum logic [1:0]
   {
      ST_SLEEP   = 2'b00,
      ST_ACQUIRE = 2'b01,
      ST_READY   = 2'b11,
      ST_CONVERT = 2'b10
   } adc_state_t;

endpackage

/* File: logic/result_fifo.sv */
// Synchronous FIFO for conversion results
`timescale 1ns/1ps
module result_fifo
#(
   parameter int WIDTH = 12,
   parameter int DEPTH = 32
)
(
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_nrst,
   // Fill side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   // Drain side
   output logic                  o_out_valid,
   output logic [WIDTH-1:0]      o_out_data,
   input  wire logic             i_out_ready
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   logic             push;
   logic             pop;

   assign o_in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
   assign o_out_valid = wr_q != rd_q;
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   assign o_out_data  = mem_q[rd_q[AW-1:0]];

   // ****************************************
   // Storage and pointers
   // ****************************************
   always_ff @(posedge i_clk)
   begin
      if (push)
      begin
         mem_q[wr_q[AW-1:0]] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

endmodule

/* File: logic/power_detector_adc_serial_readout.sv */
// Conversion control and serial readout of the detector converter
//
// Behaviour
// - A rising trigger starts a conversion and releases the serial output.
// - After a trigger rise the serial output stays undriven.
// - A finished conversion drops into sleep on its own if the trigger is still high; with it low it returns to acquisition.
// - A falling trigger drives the output and shows the top result bit at once.
// - Later bits change on falling serial clock; the host samples on rising.
// - After twelve bits the output gives zeros while the trigger stays low.
// - A trigger held high after conversion keeps the converter asleep, bias off.
// - The sample and hold stays in hold while asleep.
// - A falling trigger powers up the converter and resumes sampling.
// - After the trigger falls one acquisition interval passes before acquisition done is flagged.
// - An input above the reference gives all ones.
// - An input below ground gives all zeros.
// - The code is straight binary, one step being the reference over 4096.
// - Code boundaries sit at half steps.
`timescale 1ns/1ps
module power_detector_adc_serial_readout
   import pdadc_pkg::*;
#(
   parameter int ACQ_CNT  = ACQ_CYCLES,
   parameter int CONVERSION_TRIGGER_CNT = CONVERSION_TRIGGER_CYCLES,
   parameter int DEPTH    = FIFO_DEPTH
)
(
   // Clock and reset
   input  wire logic                   i_clk,
   input  wire logic                   i_nrst,
   // Serial pins
   input  wire logic                   i_conversion_trigger,
   input  wire logic                   i_sck,
   output logic                        o_serial_result_out,
   output logic                        o_serial_result_out_oe,
   // Detector input, signed, units of 1/16 step, full scale 4096 steps
   input  wire logic signed [IN_W-1:0] i_detector_analog_output,
   // Converter status
   output logic                        o_bias_on,
   output logic                        o_sampling,
   output logic                        o_converting,
   output logic                        o_acq_done
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic trig_m_q;
   logic trig_s_q;
   logic trig_p_q;
   logic sck_m_q;
   logic sck_s_q;
   logic sck_p_q;
   logic trig_rise;
   logic trig_fall;
   logic sck_fall;

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         trig_m_q <= 1'b0;
         trig_s_q <= 1'b0;
         trig_p_q <= 1'b0;
      end
      else
      begin
         trig_m_q <= i_conversion_trigger;
         trig_s_q <= trig_m_q;
         trig_p_q <= trig_s_q;
      end
   end

   // Sck is oversampled; each level must last at least two clocks
   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         sck_m_q <= 1'b0;
         sck_s_q <= 1'b0;
         sck_p_q <= 1'b0;
      end
      else
      begin
         sck_m_q <= i_sck;
         sck_s_q <= sck_m_q;
         sck_p_q <= sck_s_q;
      end
   end

   assign trig_rise = trig_s_q && !trig_p_q;
   assign trig_fall = !trig_s_q && trig_p_q;
   assign sck_fall  = !sck_s_q && sck_p_q;

   // ****************************************
   // Converter state machine
   // ****************************************
   adc_state_t       state_q;
   logic [CNT_W-1:0] cnt_q;
   logic             conversion_trigger_end;
   logic             fifo_in_ready;
   logic             fifo_out_valid;
   logic [RESULT_W-1:0] fifo_out_data;

   // A full FIFO holds the finished result here until room appears
   assign conversion_trigger_end = (state_q == ST_CONVERT) && (cnt_q == CNT_W'(CONVERSION_TRIGGER_CNT - 1));

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         state_q <= ST_SLEEP;
      end
      else
      begin
         case (state_q)
            ST_SLEEP:
            begin
               if (trig_fall)
               begin
                  state_q <= ST_ACQUIRE;
               end
               else if (trig_rise)
               begin
                  state_q <= ST_CONVERT;
               end
            end
            ST_ACQUIRE:
            begin
               // Early rise breaks the host's timing; the value is converted unsettled
               if (trig_rise)
               begin
                  state_q <= ST_CONVERT;
               end
               else if (cnt_q == CNT_W'(ACQ_CNT - 1))
               begin
                  state_q <= ST_READY;
               end
            end
            ST_READY:
            begin
               if (trig_rise)
               begin
                  state_q <= ST_CONVERT;
               end
            end
            ST_CONVERT:
            begin
               if (conversion_trigger_end && fifo_in_ready)
               begin
                  // Trigger already low means the wake-up edge came early
                  state_q <= trig_s_q ? ST_SLEEP : ST_ACQUIRE;
               end
            end
            default:
            begin
               state_q <= ST_SLEEP;
            end
         endcase
      end
   end

   // ****************************************
   // Interval counter
   // ****************************************
   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         cnt_q <= '0;
      end
      else if (trig_rise || trig_fall || state_q == ST_SLEEP || state_q == ST_READY)
      begin
         cnt_q <= '0;
      end
      else if (conversion_trigger_end && fifo_in_ready)
      begin
         cnt_q <= '0;
      end
      else if (conversion_trigger_end)
      begin
         // Parked on the end count while the FIFO is full
         cnt_q <= cnt_q;
      end
      else
      begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // ****************************************
   // Sample and hold, quantiser
   // ****************************************
   logic signed [IN_W-1:0] held_q;
   logic signed [IN_W:0]   rounded;
   logic [RESULT_W-1:0]    code_d;
   logic [RESULT_W-1:0]    code_q;
   logic                   track;

   // Tracking stops at the detected rise, so the held value is the one converted
   assign track = (state_q == ST_ACQUIRE || state_q == ST_READY) && !trig_rise;

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         held_q <= '0;
      end
      else if (track)
      begin
         held_q <= i_detector_analog_output;
      end
   end

   always_comb
   begin
      rounded = ($signed({held_q[IN_W-1], held_q}) + HALF_STEP) >>> FRAC_W;
      if (held_q < 0)
      begin
         code_d = CODE_ALL_ZEROS;
      end
      else if (rounded > TOP_CODE)
      begin
         code_d = CODE_ALL_ONES;
      end
      else
      begin
         code_d = rounded[RESULT_W-1:0];
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         code_q <= RESULT_RST;
      end
      else if (state_q == ST_CONVERT)
      begin
         code_q <= code_d;
      end
   end

   // ****************************************
   // Result buffer
   // ****************************************
   result_fifo
   #(
      .WIDTH (RESULT_W),
      .DEPTH (DEPTH)
   )
   u_fifo
   (
      .i_clk       (i_clk),
      .i_nrst      (i_nrst),
      .i_in_valid  (conversion_trigger_end),
      .i_in_data   (code_q),
      .o_in_ready  (fifo_in_ready),
      .o_out_valid (fifo_out_valid),
      .o_out_data  (fifo_out_data),
      .i_out_ready (trig_fall)
   );

   // ****************************************
   // Serial shifter
   // ****************************************
   logic [RESULT_W-1:0] shift_q;
   logic                oe_q;

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         oe_q <= 1'b0;
      end
      else if (trig_rise)
      begin
         oe_q <= 1'b0;
      end
      else if (trig_fall)
      begin
         oe_q <= 1'b1;
      end
   end

   // Bits only move while the trigger is low and the output is on
   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         shift_q <= RESULT_RST;
      end
      else if (trig_fall)
      begin
         // No finished result yet gives a stream of zeros
         shift_q <= fifo_out_valid ? fifo_out_data : CODE_ALL_ZEROS;
      end
      else if (sck_fall && oe_q && !trig_s_q)
      begin
         shift_q <= {shift_q[RESULT_W-2:0], 1'b0};
      end
   end

   // ****************************************
   // Status flags
   // ****************************************
   // Registered so the pins never see a decode glitch; one clock behind the state
   logic bias_q;
   logic sampling_q;
   logic converting_q;
   logic ready_q;

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         bias_q       <= 1'b0;
         sampling_q   <= 1'b0;
         converting_q <= 1'b0;
         ready_q      <= 1'b0;
      end
      else
      begin
         bias_q       <= state_q != ST_SLEEP;
         sampling_q   <= state_q == ST_ACQUIRE || state_q == ST_READY;
         converting_q <= state_q == ST_CONVERT;
         ready_q      <= state_q == ST_READY;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign o_serial_result_out    = shift_q[RESULT_W-1];
   assign o_serial_result_out_oe = oe_q;
   assign o_bias_on              = bias_q;
   assign o_sampling             = sampling_q;
   assign o_converting           = converting_q;
   assign o_acq_done             = ready_q;

endmodule

/* File: sim/readout_checker_assertions.sv */
// Port checker for the detector converter readout
`timescale 1ns/1ps
module readout_checker
   import pdadc_pkg::*;
#(
   parameter int ACQ_CNT  = 10,
   parameter int CONVERSION_TRIGGER_CNT = 40
)
(
   // Clock and reset
   input wire logic                   i_clk,
   input wire logic                   i_nrst,
   // Pins and status
   input wire logic                   i_conversion_trigger,
   input wire logic                   i_sck,
   input wire logic                   o_serial_result_out,
   input wire logic                   o_serial_result_out_oe,
   input wire logic signed [IN_W-1:0] i_detector_analog_output,
   input wire logic                   o_bias_on,
   input wire logic                   o_sampling,
   input wire logic                   o_converting,
   input wire logic                   o_acq_done
);
   logic [7:0] acq_q;
   logic [7:0] conversion_trigger_q;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // ******
   // Span counters, cleared when the span ends
   // ******
   always_ff @(posedge i_clk)
      acq_q <= (!i_nrst || !o_sampling) ? 8'h00 : acq_q + 8'h01;
   always_ff @(posedge i_clk)
      conversion_trigger_q <= (!i_nrst || !o_converting) ? 8'h00 : conversion_trigger_q + 8'h01;
   // ******
   // Properties
   // ******
   out_release_a: assert property ($rose(i_conversion_trigger) |-> ##[1:5] !o_serial_result_out_oe)
      else $error("output not released after trigger rise");
   high_z_a: assert property (i_conversion_trigger && $past(i_conversion_trigger, 5) |-> !o_serial_result_out_oe)
      else $error("output driven while trigger high");
   out_enable_a: assert property ($fell(i_conversion_trigger) |-> ##[2:5] o_serial_result_out_oe)
      else $error("output not enabled after trigger fall");
   sleep_entry_a: assert property ($fell(o_converting) && i_conversion_trigger |-> !o_bias_on)
      else $error("no sleep after conversion");
   hold_sleep_a: assert property (!o_bias_on |-> !o_sampling)
      else $error("sampling while asleep");
   wake_up_a: assert property ($fell(i_conversion_trigger) |-> ##[2:5] (o_bias_on && o_sampling))
      else $error("no wake after trigger fall");
   acq_span_a: assert property ($rose(o_acq_done) |-> acq_q inside {[ACQ_CNT-1:ACQ_CNT+1]})
      else $error("acquisition span wrong");
   conversion_trigger_span_a: assert property ($fell(o_converting) |-> conversion_trigger_q inside {[CONVERSION_TRIGGER_CNT-1:CONVERSION_TRIGGER_CNT+2]})
      else $error("conversion span wrong");
   shift_edge_a: assert property (o_serial_result_out_oe && $past(o_serial_result_out_oe)
      && $changed(o_serial_result_out) |-> $past(i_sck, 5) && !$past(i_sck, 2))
      else $error("data moved without sck fall");
   cover property ($fell(o_converting));
   cover property ($rose(o_acq_done));
   cover property ($rose(o_serial_result_out_oe));
endmodule
bind power_detector_adc_serial_readout readout_checker
#(
   .ACQ_CNT(ACQ_CNT),
   .CONVERSION_TRIGGER_CNT(CONVERSION_TRIGGER_CNT)
)
i_readout_checker
(
   .i_clk(i_clk), .i_nrst(i_nrst), .i_conversion_trigger(i_conversion_trigger),
   .i_sck(i_sck), .o_serial_result_out(o_serial_result_out),
   .o_serial_result_out_oe(o_serial_result_out_oe),
   .i_detector_analog_output(i_detector_analog_output), .o_bias_on(o_bias_on),
   .o_sampling(o_sampling), .o_converting(o_converting), .o_acq_done(o_acq_done)
);

/* File: sim/serial_host_model.sv */
// Serial host driving trigger and serial clock
`timescale 1ns/1ps
module serial_host_model
#(
   parameter int HOLD = 60
)
(
   input  wire logic i_clk,
   input  wire logic i_sdo,
   input  wire logic i_oe,
   output logic      o_trig,
   output logic      o_sck
);
   logic last_q;
   logic line;
   initial
   begin
      o_trig = 1'b0;
      o_sck  = 1'b0;
   end
   // Released line shows the inverse, never a stale bit
   always @(posedge i_clk)
      if (i_oe)
         last_q <= i_sdo;
   assign line = i_oe ? i_sdo : ~last_q;
   task automatic start(input bit noise);
      @(posedge i_clk);
      o_trig <= 1'b1;
      for (int i = 0; i < HOLD; i++)
      begin
         @(posedge i_clk);
         o_sck <= noise & i[2];
      end
      @(posedge i_clk);
      o_sck <= 1'b0;
      repeat (8) @(posedge i_clk);
   endtask
   task automatic read(input int n, output logic [15:0] w);
      @(posedge i_clk);
      o_trig <= 1'b0;
      w = 16'h0000;
      repeat (12) @(posedge i_clk);
      for (int i = 0; i < n; i++)
      begin
         o_sck <= 1'b1;
         repeat (3) @(posedge i_clk);
         @(negedge i_clk);
         w = {w[14:0], line};
         @(posedge i_clk);
         o_sck <= 1'b0;
         repeat (4) @(posedge i_clk);
      end
   endtask
endmodule

/* File: sim/tb_power_detector_adc_serial_readout.sv */
// Testbench for the detector converter readout
`timescale 1ns/1ps
module tb_power_detector_adc_serial_readout;
   import pdadc_pkg::*;
   logic                   clk;
   logic                   nrst;
   logic                   trig;
   logic                   sck;
   logic                   serial_result_out;
   logic                   oe;
   logic                   bias;
   logic                   smp;
   logic                   conversion_trigger;
   logic                   acq;
   logic signed [IN_W-1:0] vin;
   int                     mismatches;
   int                     samples_checked;
   int                     cycles;
   // Short counts keep the run brief
   power_detector_adc_serial_readout #(.ACQ_CNT(3), .CONVERSION_TRIGGER_CNT(5))
   i_power_detector_adc_serial_readout
   (
      .i_clk(clk), .i_nrst(nrst), .i_conversion_trigger(trig), .i_sck(sck),
      .o_serial_result_out(serial_result_out), .o_serial_result_out_oe(oe),
      .i_detector_analog_output(vin), .o_bias_on(bias), .o_sampling(smp),
      .o_converting(conversion_trigger), .o_acq_done(acq)
   );
   serial_host_model i_serial_host_model
   (
      .i_clk(clk), .i_sdo(serial_result_out), .i_oe(oe), .o_trig(trig), .o_sck(sck)
   );
   // ******
   // Checking
   // ******
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({15'h0000, got}, {15'h0000, exp});
   endtask
   function automatic logic [11:0] code_of(input int v);
      int c;
      c = (v + 8) / 16;
      if (v < 0)
         return 12'h000;
      if (c > 4095)
         return 12'hfff;
      return c[11:0];
   endfunction
   task automatic final_report();
      if (mismatches == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ******
   // Scenarios
   // ******
   task automatic s_codes();
      int          tbl[9] = '{0, 7, 8, 24, -16, 65520, 524287, 42432, 23097};
      logic [15:0] w;
      foreach (tbl[k])
      begin
         vin <= tbl[k][IN_W-1:0];
         i_serial_host_model.start(1'b0);
         chk_bit(oe, 1'b0);
         chk_bit(bias, 1'b0);
         chk_bit(conversion_trigger, 1'b0);
         chk_bit(smp, 1'b0);
         i_serial_host_model.read(16, w);
         chk_bit(bias & smp, 1'b1);
         chk_bit(acq, 1'b1);
         chk_word(w, {code_of(tbl[k]), 4'h0});
      end
   endtask
   task automatic s_abort();
      logic [15:0] w;
      logic [11:0] c;
      c = code_of(46000);
      vin <= 20'sd46000;
      i_serial_host_model.start(1'b0);
      i_serial_host_model.read(5, w);
      chk_word(w, {11'h000, c[11:7]});
      i_serial_host_model.start(1'b1);
      i_serial_host_model.read(16, w);
      chk_word(w, {c, 4'h0});
   endtask
   // ******
   // Run control
   // ******
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         final_report();
      end
   end
   initial
   begin
      nrst = 1'b0;
      vin  = '0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      s_codes();
      s_abort();
      final_report();
   end
endmodule
